// file: shared/sdct_pkg.sv
// Constants, command codes and state record for the synchronous DRAM command engine.
// Assumes one clock (clk_sys) shared with the memory controller and a fixed CAS latency.
// Operation
// - First read data appears three cycles after the read command.
// - A new column command is accepted every single cycle.
// - Burst stop during read floats the data outputs three cycles later.
// - Burst stop during write ignores write data from that cycle.
// - Precharge ending a read floats the outputs three cycles later.
// - Precharge ending a write ignores write data from that cycle.
// - Read auto-precharge starts internally two cycles before the last data.
// - A read byte mask disables the matching output byte two cycles later.
// - A write byte mask blocks the matching input byte in that cycle.
// - Precharge with precharge-select high closes both banks, else the selected one.
// - Column command with precharge-select high closes the bank after the burst.
package sdct_pkg;

    // Latencies in clock cycles
    localparam int CAS_LAT_CYC     = 3;  // read command to first data
    localparam int CLOSE_FLOAT_CYC = 3;  // stop or precharge to outputs floating
    localparam int MASK_RD_CYC     = 2;  // read mask to output byte
    localparam int AUTOCLOSE_LEAD  = 2;  // autoclose_start_offset, fastest grade

    // Field positions on the address pins
    localparam int PRE_SEL_BIT     = 10; // precharge_select_line
    localparam int BANK_SEL_BIT    = 11; // bank_select_line

    // Values after reset
    localparam logic [7:0] BL_MASK_RST = 8'h00; // burst length one until mode set

    // Command codes on {ras_n, cas_n, we_n} with chip select low
    typedef enum logic [2:0] {
        SDCT_MODE_SET = 3'b000,
        SDCT_REFRESH  = 3'b001,
        SDCT_PRECHG   = 3'b010,
        SDCT_ACTIVATE = 3'b011,
        SDCT_WRITE    = 3'b100,
        SDCT_READ     = 3'b101,
        SDCT_STOP     = 3'b110,
        SDCT_NOP      = 3'b111
    } sdct_cmd_t;

    // Whole state of the engine
    typedef struct packed {
        logic [1:0]       bank_open;
        logic [1:0][10:0] open_row;
        logic [7:0]       bl_mask;
        logic             rd_act;
        logic             wr_act;
        logic             ap;
        logic             bank;
        logic [7:0]       col;
        logic [7:0]       remain;
        logic             arr_rd;
        logic             arr_wr;
        logic             arr_bank;
        logic [10:0]      arr_row;
        logic [7:0]       arr_col;
        logic [15:0]      arr_wdata;
        logic [1:0]       arr_be;
        logic             p1_v;
        logic [15:0]      p1_d;
        logic             p2_v;
        logic [15:0]      p2_d;
        logic [1:0]       m1;
        logic [1:0]       m2;
        logic [15:0]      dq_out;
        logic [1:0]       dq_oe;
        logic [1:0]       close_pend;
        logic [1:0]       close_start;
    } sdct_state_t;

endpackage

// file: design/sdct_engine.sv
// Command engine of a two-bank 16-bit synchronous DRAM: decodes pin commands,
// runs read and write bursts against a storage array, drives the data pins.
// Assumes the array answers arr_rdata combinationally for arr_bank/arr_row/arr_col.
`timescale 1ns/1ps
module sdct_engine
    import sdct_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Command pins
    input  wire logic        cke,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [11:0] addr,
    input  wire logic [1:0]  dqm,
    // Data pins, split into input, output and per-byte enable
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic      [1:0]  dq_oe,
    // Storage array side
    output logic             arr_rd,
    output logic             arr_wr,
    output logic             arr_bank,
    output logic      [10:0] arr_row,
    output logic      [7:0]  arr_col,
    output logic      [15:0] arr_wdata,
    output logic      [1:0]  arr_be,
    input  wire logic [15:0] arr_rdata,
    // Bank status
    output logic      [1:0]  bank_open,
    output logic      [1:0]  close_start
);

    sdct_state_t s;
    sdct_state_t next_s;
    sdct_cmd_t   cmd;
    logic        take;
    logic        ba;
    logic        stop_here;

    // One-hot bank selection
    function automatic logic [1:0] bank_sel(input logic b);
        bank_sel = b ? 2'h2 : 2'h1;
    endfunction

    // Burst length field to a wrap mask; unknown codes fall back to one word
    function automatic logic [7:0] bl_decode(input logic [2:0] f);
        case (f)
            3'h1:    bl_decode = 8'h01;
            3'h2:    bl_decode = 8'h03;
            3'h3:    bl_decode = 8'h07;
            3'h7:    bl_decode = 8'hFF;
            default: bl_decode = 8'h00;
        endcase
    endfunction

    // Command decode; clock enable low suspends the whole engine
    assign cmd  = sdct_cmd_t'({ras_n, cas_n, we_n});
    assign take = cke & ~cs_n;
    assign ba   = addr[BANK_SEL_BIT];

    // Next-state logic
    always_comb begin
        next_s    = s;
        stop_here = 1'b0;
        if (cke) begin
            // Read pipeline: array word, two stages, then the pins
            next_s.p1_v        = s.arr_rd;
            next_s.p1_d        = arr_rdata;
            next_s.p2_v        = s.p1_v;
            next_s.p2_d        = s.p1_d;
            next_s.m1          = dqm;
            next_s.m2          = s.m1;
            next_s.dq_out      = s.p2_d;
            next_s.dq_oe       = {2{s.p2_v}} & ~s.m2;
            next_s.arr_rd      = 1'b0;
            next_s.arr_wr      = 1'b0;
            // Internal close lands one edge after the last word is issued
            next_s.close_start = s.close_pend;
            next_s.bank_open   = s.bank_open & ~s.close_pend;
            next_s.close_pend  = 2'h0;
            // Burst continuation, one word per cycle within the wrap block
            if (s.rd_act || s.wr_act) begin
                next_s.col       = (s.col & ~s.bl_mask) | (8'(s.col + 8'h01) & s.bl_mask);
                next_s.arr_col   = next_s.col;
                next_s.arr_bank  = s.bank;
                next_s.arr_row   = s.open_row[s.bank];
                next_s.arr_rd    = s.rd_act;
                next_s.arr_wr    = s.wr_act;
                next_s.arr_wdata = dq_in;
                next_s.arr_be    = ~dqm;
                next_s.remain    = 8'(s.remain - 8'h01);
                if (s.remain == 8'h01) begin
                    next_s.rd_act = 1'b0;
                    next_s.wr_act = 1'b0;
                    if (s.ap) begin
                        next_s.close_pend = bank_sel(s.bank);
                    end
                end
            end
            // Pin command; it overrides the continuation above
            if (take) begin
                case (cmd)
                    SDCT_ACTIVATE: begin
                        next_s.bank_open[ba] = 1'b1;
                        next_s.open_row[ba]  = addr[10:0];
                    end
                    SDCT_READ, SDCT_WRITE: begin
                        // A column command every cycle restarts the burst
                        next_s.rd_act    = (cmd == SDCT_READ) && (s.bl_mask != 8'h00);
                        next_s.wr_act    = (cmd == SDCT_WRITE) && (s.bl_mask != 8'h00);
                        next_s.ap        = addr[PRE_SEL_BIT];
                        next_s.bank      = ba;
                        next_s.col       = addr[7:0];
                        next_s.remain    = s.bl_mask;
                        next_s.arr_rd    = (cmd == SDCT_READ);
                        next_s.arr_wr    = (cmd == SDCT_WRITE);
                        next_s.arr_bank  = ba;
                        next_s.arr_row   = s.open_row[ba];
                        next_s.arr_col   = addr[7:0];
                        next_s.arr_wdata = dq_in;
                        next_s.arr_be    = ~dqm;
                        next_s.close_pend = (addr[PRE_SEL_BIT] && s.bl_mask == 8'h00)
                                          ? bank_sel(ba) : 2'h0;
                    end
                    SDCT_PRECHG: begin
                        // Both banks with the select line high, else one bank
                        next_s.bank_open = next_s.bank_open
                            & ~(addr[PRE_SEL_BIT] ? 2'h3 : bank_sel(ba));
                        stop_here = addr[PRE_SEL_BIT] || (ba == s.bank);
                    end
                    SDCT_STOP: begin
                        stop_here = 1'b1;
                    end
                    SDCT_MODE_SET: begin
                        next_s.bl_mask = bl_decode(addr[2:0]);
                    end
                    default: begin
                    end
                endcase
            end
            // Ending a burst drops this cycle's word: write data is ignored at
            // once and reads already in the pipe drain, so pins float 3 later
            if (stop_here) begin
                next_s.rd_act     = 1'b0;
                next_s.wr_act     = 1'b0;
                next_s.arr_rd     = 1'b0;
                next_s.arr_wr     = 1'b0;
                next_s.close_pend = 2'h0;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s         <= '0;
            s.bl_mask <= BL_MASK_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign dq_out      = s.dq_out;
    assign dq_oe       = s.dq_oe;
    assign arr_rd      = s.arr_rd;
    assign arr_wr      = s.arr_wr;
    assign arr_bank    = s.arr_bank;
    assign arr_row     = s.arr_row;
    assign arr_col     = s.arr_col;
    assign arr_wdata   = s.arr_wdata;
    assign arr_be      = s.arr_be;
    assign bank_open   = s.bank_open;
    assign close_start = s.close_start;

    // Assertions
    property p_rd_latency;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_READ) ##1 (cke && dqm == 2'h0) [*3]
        |=> (dq_oe == 2'h3) && (dq_out == $past(arr_rdata, 3));
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read data late");

    property p_col_each;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_READ) |=> arr_rd && arr_col == $past(addr[7:0]);
    endproperty
    a_col_each: assert property (p_col_each) else $error("column not taken");

    property p_stop_rd;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_STOP) ##1 (cke && !(take && cmd == SDCT_READ)) [*3]
        |=> dq_oe == 2'h0;
    endproperty
    a_stop_rd: assert property (p_stop_rd) else $error("outputs not floated");

    property p_stop_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_STOP) |=> !arr_wr && !arr_rd;
    endproperty
    a_stop_wr: assert property (p_stop_wr) else $error("data after stop");

    property p_pre_rd;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_PRECHG && addr[PRE_SEL_BIT])
        ##1 (cke && !(take && cmd == SDCT_READ)) [*3] |=> dq_oe == 2'h0;
    endproperty
    a_pre_rd: assert property (p_pre_rd) else $error("precharge float late");

    // Covers a close-all and a single-bank close aimed at the bursting bank
    property p_pre_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_PRECHG && (addr[PRE_SEL_BIT] || ba == s.bank)) |=> !arr_wr;
    endproperty
    a_pre_wr: assert property (p_pre_wr) else $error("write after precharge");

    // Two-word read: last word leaves one edge later, the close one edge after
    // that; only a new column command, stop or precharge may cancel it
    property p_autoclose;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_READ && addr[PRE_SEL_BIT] && s.bl_mask == 8'h01)
        ##1 (cke && !(take && cmd inside {SDCT_READ, SDCT_WRITE, SDCT_PRECHG, SDCT_STOP}))
        ##1 (cke && !(take && cmd == SDCT_ACTIVATE))
        |=> close_start == bank_sel($past(ba, 3)) && !bank_open[$past(ba, 3)];
    endproperty
    a_autoclose: assert property (p_autoclose) else $error("autoclose timing");

    property p_mask_rd;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_READ) ##1 (cke && dqm == 2'h1) ##1 (cke && dqm == 2'h0) [*2]
        |=> dq_oe == 2'h2;
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("read mask delay");

    property p_mask_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_WRITE)
        |=> arr_wr && arr_be == ~$past(dqm) && arr_wdata == $past(dq_in);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("write mask delay");

    property p_pre_close;
        @(posedge clk_sys) disable iff (!rst_n)
        (take && cmd == SDCT_PRECHG && !addr[PRE_SEL_BIT] && cke)
        |=> !bank_open[$past(ba)]
        && bank_open[!$past(ba)] == $past(bank_open[!ba] && !s.close_pend[!ba]);
    endproperty
    a_pre_close: assert property (p_pre_close) else $error("wrong bank closed");

endmodule // sdct_engine

// file: verif/sdct_ctl_model.sv
// Controller model: drives command, mask and write data pins of the engine.
// Assumes one shared clock; the bench calls issue() once per command.
`timescale 1ns/1ps
module sdct_ctl_model
    import sdct_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Command and data pins
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic      [11:0] addr,
    output logic      [1:0]  dqm,
    output logic      [15:0] dq_in
);
    int         cyc = 0;
    int         ta[2] = '{-99, -99};
    int         tp[2] = '{-99, -99};
    int         tx = -99;
    int         tm = -99;
    int         tw = -99;
    logic [1:0] opened = 2'b00;

    // Edge count; gaps kept in whole cycles, per bank for activate and precharge
    always @(posedge clk_sys) cyc <= cyc + 1;

    // Idle as nop; clock enable stays high, so no wake-up gap arises
    // Run starts after power-up and is far shorter than a refresh period
    initial begin
        cke = 1'b1;
        cs_n = 1'b0;
        {ras_n, cas_n, we_n} = SDCT_NOP;
        addr = 12'h000;
        dqm = 2'b00;
        dq_in = 16'h0000;
    end

    // May a command be taken at edge n
    function automatic bit legal(sdct_cmd_t c, logic b, int n);
        if (n - tm < 2) return 1'b0;
        case (c)
            SDCT_ACTIVATE: return n - ta[b] >= 9 && n - tw >= 4 &&
                                  n - tp[b] >= 3 && n - tx >= 3;
            SDCT_READ, SDCT_WRITE: return n - ta[b] >= 3;
            SDCT_PRECHG: return n - ta[b] >= 6 && n - tw >= 2;
            SDCT_MODE_SET: return opened == 2'b00;
            default: return 1'b1;
        endcase
    endfunction

    // Drive one command; nops fill in until its spacing is met
    task automatic issue(sdct_cmd_t c, logic [11:0] a, logic [1:0] m = 2'b00,
                         logic [15:0] d = 16'h0000, bit drv = 1'b0);
        int         n;
        logic       b;
        logic [1:0] hit;
        b = a[BANK_SEL_BIT];
        hit = (c == SDCT_PRECHG && a[PRE_SEL_BIT]) ? 2'b11 : 2'(2'b01 << b);
        @(posedge clk_sys);
        while (!legal(c, b, cyc + 2)) begin
            {ras_n, cas_n, we_n} <= SDCT_NOP;
            dq_in <= ~dq_in;
            @(posedge clk_sys);
        end
        n = cyc + 2;
        {ras_n, cas_n, we_n} <= c;
        addr <= a;
        dqm <= m;
        dq_in <= drv ? d : ~dq_in; // Undriven bus never repeats a stale word
        if (drv) tw = n;
        if (c == SDCT_MODE_SET) tm = n;
        if (c == SDCT_ACTIVATE) begin
            ta[b] = n;
            tx = n;
            opened[b] = 1'b1;
        end
        // Auto close lands later, so a wide margin is booked
        if (c == SDCT_PRECHG || (c inside {SDCT_READ, SDCT_WRITE} && a[PRE_SEL_BIT])) begin
            opened &= ~hit;
            for (int i = 0; i < 2; i++)
                if (hit[i]) tp[i] = n + 8;
        end
    endtask
endmodule // sdct_ctl_model

// file: verif/tb_top.sv
// Bench for the command engine: bursts, stops, masks and bank closing.
// Assumes the controller model drives all pins; the array returns a pattern.
`timescale 1ns/1ps
module tb_top
    import sdct_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        cke, cs_n, ras_n, cas_n, we_n, arr_rd, arr_wr, arr_bank;
    logic [11:0] addr;
    logic [10:0] arr_row;
    logic [7:0]  arr_col;
    logic [1:0]  dqm, dq_oe, arr_be, bank_open, close_start;
    logic [15:0] dq_in, dq_out, arr_wdata, arr_rdata;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cycles = 0;

    // Array word is a pure function of its location
    function automatic logic [15:0] pat(logic b, logic [10:0] r, logic [7:0] c);
        return {b, r[6:0], c};
    endfunction
    assign arr_rdata = pat(arr_bank, arr_row, arr_col);

    always #10 clk_sys = ~clk_sys;

    sdct_engine uut (.clk_sys, .rst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .dqm,
        .dq_in, .dq_out, .dq_oe, .arr_rd, .arr_wr, .arr_bank, .arr_row, .arr_col,
        .arr_wdata, .arr_be, .arr_rdata, .bank_open, .close_start);
    sdct_ctl_model ctl (.clk_sys, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .dqm, .dq_in);

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Sequence needs under 100 cycles; a hang is cut well beyond that
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Wait k edges, then let their updates settle
    task automatic step(int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Two-word read, low byte masked on the first word only
    task automatic t_read_mask();
        ctl.issue(SDCT_MODE_SET, 12'h001);
        ctl.issue(SDCT_ACTIVATE, 12'h005);
        ctl.issue(SDCT_READ, 12'h007);
        ctl.issue(SDCT_NOP, 12'h000, 2'b01);
        ctl.issue(SDCT_NOP, 12'h000);
        step(1);
        chk(16'(dq_oe), 16'h0000);
        step(1);
        chk(16'(dq_oe), 16'h0002);
        chk(dq_out & 16'hFF00, pat(1'b0, 11'h005, 8'h07) & 16'hFF00);
        step(1);
        chk(16'(dq_oe), 16'h0003);
        chk(dq_out, pat(1'b0, 11'h005, 8'h06));
        step(1);
        chk(16'(dq_oe), 16'h0000);
        $display("test read_mask done");
    endtask

    // Read with automatic close: bank shuts two cycles before last data
    task automatic t_autoclose();
        ctl.issue(SDCT_READ, 12'h402);
        ctl.issue(SDCT_NOP, 12'h000);
        step(1);
        chk(16'(bank_open), 16'h0001);
        step(1);
        chk(16'(close_start), 16'h0001);
        chk(16'(bank_open), 16'h0000);
        step(2);
        chk(dq_out, pat(1'b0, 11'h005, 8'h03));
        $display("test autoclose done");
    endtask

    // Back-to-back reads, then a stop floats the pins three cycles later
    task automatic t_stop();
        ctl.issue(SDCT_MODE_SET, 12'h003);
        ctl.issue(SDCT_ACTIVATE, 12'h809);
        ctl.issue(SDCT_READ, 12'h810);
        ctl.issue(SDCT_READ, 12'h820);
        ctl.issue(SDCT_STOP, 12'h000);
        ctl.issue(SDCT_NOP, 12'h000);
        step(1);
        chk(dq_out, pat(1'b1, 11'h009, 8'h10));
        step(1);
        chk(dq_out, pat(1'b1, 11'h009, 8'h20));
        chk(16'(dq_oe), 16'h0003);
        step(1);
        chk(16'(dq_oe), 16'h0000);
        $display("test stop done");
    endtask

    // Close-all precharge cuts a long read short
    task automatic t_pre_read();
        ctl.issue(SDCT_ACTIVATE, 12'h003);
        ctl.issue(SDCT_READ, 12'h000);
        ctl.issue(SDCT_PRECHG, 12'h400);
        ctl.issue(SDCT_NOP, 12'h000);
        step(0);
        chk(16'(bank_open), 16'h0000);
        chk(16'(arr_rd), 16'h0000);
        step(2);
        chk(16'(dq_oe), 16'h0003);
        step(1);
        chk(16'(dq_oe), 16'h0000);
        $display("test pre_read done");
    endtask

    // Masked write, stop in mid-burst, then one bank closed alone
    task automatic t_write();
        ctl.issue(SDCT_ACTIVATE, 12'h004);
        ctl.issue(SDCT_ACTIVATE, 12'h804);
        ctl.issue(SDCT_WRITE, 12'h830, 2'b01, 16'hA5C3, 1'b1);
        ctl.issue(SDCT_NOP, 12'h000, 2'b00, 16'h5A3C, 1'b1);
        step(0);
        chk(16'(arr_wr), 16'h0001);
        chk(arr_wdata, 16'hA5C3);
        chk(16'(arr_be), 16'h0002);
        chk(16'(arr_col), 16'h0030);
        ctl.issue(SDCT_STOP, 12'h000, 2'b00, 16'h1111, 1'b1);
        step(0);
        chk(arr_wdata, 16'h5A3C);
        chk(16'(arr_be), 16'h0003);
        ctl.issue(SDCT_NOP, 12'h000);
        step(0);
        chk(16'(arr_wr), 16'h0000);
        // Bank 0 burst cut by its own precharge; data at that edge is dropped
        ctl.issue(SDCT_WRITE, 12'h040, 2'b00, 16'h1234, 1'b1);
        ctl.issue(SDCT_PRECHG, 12'h000, 2'b00, 16'h0F0F, 1'b1);
        ctl.issue(SDCT_NOP, 12'h000);
        step(0);
        chk(16'(arr_wr), 16'h0000);
        chk(16'(bank_open), 16'h0002);
        $display("test write done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        step(7);
        chk(16'({dq_oe, bank_open, close_start}), 16'h0000);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        $display("test reset done");
        t_read_mask();
        t_autoclose();
        t_stop();
        t_pre_read();
        t_write();
        close_out();
    end
endmodule // tb_top
